// ---- src/sfe_regs.svh ----
// Constants of the serial flash erase and power-down sequencer.
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH

// System clock rate in MHz.
`define SFE_MCLK_MHZ 25

// Command byte defaults; every value is arbitrary.
`define SFE_CMD_WRITE_ENABLE  8'h10
`define SFE_CMD_WRITE_DISABLE 8'h11
`define SFE_CMD_LOCK_WRITE    8'h12
`define SFE_CMD_PAGE_CLEAR    8'h13
`define SFE_CMD_SECTOR_CLEAR  8'h14
`define SFE_CMD_SUB_CLEAR     8'h15
`define SFE_CMD_ARRAY_CLEAR   8'h16
`define SFE_CMD_POWERDOWN     8'h17
`define SFE_CMD_RELEASE       8'h18

// Legal frame lengths in serial bits, and the saturation limit of the bit count.
`define SFE_LEN_CMD  6'h08
`define SFE_LEN_ADDR 6'h20
`define SFE_LEN_LOCK 6'h28
`define SFE_LEN_MAX  6'h3f

// Address fields; the top three address bits are never decoded.
`define SFE_ADDR_MSB   20
`define SFE_SECT_LSB   16
`define SFE_SUB_MSB    15
`define SFE_SUB_LSB    12
`define SFE_SECT_LAST  5'h1f

// Lock data byte fields.
`define SFE_LK_WL     0
`define SFE_LK_LD     1
`define SFE_LK_SUB_WL 2
`define SFE_LK_SUB_LD 3
`define SFE_LK_SUB    7

// Times in their own units, and cycle counts derived from them.
`define SFE_PAGE_CLEAR_TIME_US      10000
`define SFE_SECTOR_CLEAR_TIME_US    100000
`define SFE_SUBSECTOR_CLEAR_TIME_US 50000
`define SFE_ARRAY_CLEAR_TIME_US     1000000
`define SFE_POWERDOWN_ENTRY_DELAY_NS 3000
`define SFE_RESET_TO_SELECT_DELAY_NS 30000
`define SFE_US_CYCLES(t) ((t) * `SFE_MCLK_MHZ)
`define SFE_NS_CYCLES(t) (((t) * `SFE_MCLK_MHZ + 999) / 1000)
`define SFE_PAGE_CLEAR_CYCLES `SFE_US_CYCLES(`SFE_PAGE_CLEAR_TIME_US)
`define SFE_SECTOR_CLEAR_CYCLES `SFE_US_CYCLES(`SFE_SECTOR_CLEAR_TIME_US)
`define SFE_SUB_CLEAR_CYCLES `SFE_US_CYCLES(`SFE_SUBSECTOR_CLEAR_TIME_US)
`define SFE_ARRAY_CLEAR_CYCLES `SFE_US_CYCLES(`SFE_ARRAY_CLEAR_TIME_US)
`define SFE_PD_CYCLES `SFE_NS_CYCLES(`SFE_POWERDOWN_ENTRY_DELAY_NS)
`define SFE_RHSL_CYCLES `SFE_NS_CYCLES(`SFE_RESET_TO_SELECT_DELAY_NS)

`endif

// ---- src/sfe_pkg.sv ----
// Types shared by the erase and power-down sequencer.
package sfe_pkg;

    // Operating modes of the sequencer.
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ERASE,
        ST_PD_WAIT,
        ST_DEEP,
        ST_RESET
    } sfe_state_type;

    // Kind of region that a running erase clears.
    typedef enum logic [1:0] {
        KIND_PAGE,
        KIND_SECTOR,
        KIND_SUB,
        KIND_ARRAY
    } sfe_kind_type;

endpackage

// ---- src/sfe_sync.sv ----
// Two-stage synchroniser for levels entering the system clock domain.
module sfe_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1; // Metastable stage, read by stage two only.

    // Both stages reset to the idle level of the input.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= INIT;
            dout   <= INIT;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

// ---- src/sfe_erase_ctl.sv ----
// Erase, lock and deep power-down command sequencer of a serial flash.
//
// Behaviour
// - Clearing last sector lock frees unfrozen subsectors
// - Write-locked regions reject every erase command
// - Lock write applies write-lock before freeze
// - Page erase sets the whole page to ones
// - Erases need the write latch flag set
// - Select rising off the address boundary discards
// - Select rise starts erase; active flag held
// - Write latch cleared during every erase cycle
// - Protected page is never page erased
// - Commands during a running cycle are rejected
// - Reset pin aborts erase, enters reset mode
// - Three top address bits are ignored
// - Sector erase refused on hardware-protected sector
// - Subsector erase refused when sector protected
// - One-byte commands need select after byte
// - Array erase refused while anything is protected
// - Deep power-down ignores write and erase
// - Deep power-down entered only from standby
// - Reset always returns to standby mode
// - Power-down mode entered after entry delay
// - Clearing first sector lock frees unfrozen subsectors
// - Locking first or last sector locks subsectors
// - Only release or a reset leaves deep power-down
`include "sfe_regs.svh"

module sfe_erase_ctl #(
    parameter logic [7:0]  CMD_WRITE_ENABLE  = `SFE_CMD_WRITE_ENABLE,
    parameter logic [7:0]  CMD_WRITE_DISABLE = `SFE_CMD_WRITE_DISABLE,
    parameter logic [7:0]  CMD_LOCK_WRITE    = `SFE_CMD_LOCK_WRITE,
    parameter logic [7:0]  CMD_PAGE_CLEAR    = `SFE_CMD_PAGE_CLEAR,
    parameter logic [7:0]  CMD_SECTOR_CLEAR  = `SFE_CMD_SECTOR_CLEAR,
    parameter logic [7:0]  CMD_SUB_CLEAR     = `SFE_CMD_SUB_CLEAR,
    parameter logic [7:0]  CMD_ARRAY_CLEAR   = `SFE_CMD_ARRAY_CLEAR,
    parameter logic [7:0]  CMD_POWERDOWN     = `SFE_CMD_POWERDOWN,
    parameter logic [7:0]  CMD_RELEASE       = `SFE_CMD_RELEASE,
    parameter logic [31:0] PAGE_CLEAR_CYCLES   = `SFE_PAGE_CLEAR_CYCLES,
    parameter logic [31:0] SECTOR_CLEAR_CYCLES = `SFE_SECTOR_CLEAR_CYCLES,
    parameter logic [31:0] SUB_CLEAR_CYCLES    = `SFE_SUB_CLEAR_CYCLES,
    parameter logic [31:0] ARRAY_CLEAR_CYCLES  = `SFE_ARRAY_CLEAR_CYCLES
)(
    input  wire logic                  MCLK,
    input  wire logic                  SRST,
    input  wire logic                  SCLK,
    input  wire logic                  SEL_N,
    input  wire logic                  SERIAL_IN,
    input  wire logic                  RESET_N,
    input  wire logic [31:0]           HW_PROTECT,
    input  wire logic                  EXT_BUSY,
    output logic                       CYCLE_ACTIVE,
    output logic                       WRITE_LATCH,
    output logic                       DEEP_POWERDOWN,
    output logic                       ERASE_START,
    output logic                       ERASE_ABORT,
    output sfe_pkg::sfe_kind_type      ERASE_KIND,
    output logic [20:0]                ERASE_ADDR,
    output logic                       CMD_REJECT
);

    // Link side: shift register and bit count on the serial clock.
    logic        started;   // Cleared while deselected.
    logic [39:0] shift;     // Serial bits, newest in bit zero.
    logic [5:0]  count;     // Bits seen in this frame, saturating.

    // The select pin clears the frame marker so that the first edge
    // of a frame restarts the count; no edge is expected outside it.
    always_ff @(posedge SCLK or posedge SEL_N)
    begin
        if (SEL_N)
            started <= 1'b0;
        else
            started <= 1'b1;
    end

    // Bits are taken on the rising serial clock edge.
    always_ff @(posedge SCLK)
    begin
        if (!started)
        begin
            shift <= {39'h0, SERIAL_IN};
            count <= 6'h01;
        end
        else
        begin
            shift <= {shift[38:0], SERIAL_IN};
            count <= (count == `SFE_LEN_MAX) ? count : 6'(count + 6'h01);
        end
    end

    // Select and reset pins pass two flip-flops before the system logic reads them.
    logic [1:0] pins_sync; // Bit 1 select, bit 0 reset pin.

    sfe_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_pin_sync (
        .clk  (MCLK),
        .rst  (SRST),
        .din  ({SEL_N, RESET_N}),
        .dout (pins_sync)
    );

    // System side state.
    sfe_pkg::sfe_state_type state;       // Operating mode.
    sfe_pkg::sfe_state_type next_state;  // Mode for the next edge.
    logic [31:0]            timer;       // Remaining cycles in a mode.
    logic [31:0]            next_timer;  // Timer for the next edge.
    sfe_pkg::sfe_kind_type  next_kind;   // Kind to present next.
    logic [20:0]            next_addr;   // Address to present next.
    logic                   sel_prev;    // Select level one edge ago.
    logic [31:0]            sect_wl;     // Sector write-lock bits.
    logic [31:0]            sect_ld;     // Sector lock-freeze bits.
    logic [1:0][15:0]       sub_wl;      // Subsector locks, end sectors.
    logic [1:0][15:0]       sub_ld;      // Subsector freezes, end sectors.
    logic                   next_latch;  // Write latch for next edge.

    // A frame ends on the synchronised select rise; the serial clock
    // has stopped by then, so the link registers are stable to read.
    wire frame_end = pins_sync[1] & ~sel_prev;
    wire pin_reset = ~pins_sync[0];
    wire len_cmd   = (count == `SFE_LEN_CMD);
    wire len_addr  = (count == `SFE_LEN_ADDR);
    wire len_lock  = (count == `SFE_LEN_LOCK);
    wire [7:0] cmd = len_lock ? shift[39:32] :
                     len_addr ? shift[31:24] : shift[7:0];
    wire [20:0] addr  = len_lock ? shift[28:8] : shift[20:0];
    wire [7:0]  lk    = shift[7:0];
    wire [4:0]  sect  = addr[`SFE_ADDR_MSB:`SFE_SECT_LSB];
    wire [3:0]  sub   = addr[`SFE_SUB_MSB:`SFE_SUB_LSB];
    wire        first = (sect == 5'h00);
    wire        last  = (sect == `SFE_SECT_LAST);
    wire [15:0] sub_mask = 16'h0001 << sub;

    // Subsector locks of the addressed sector; only the end sectors
    // carry them, the others read as all clear.
    wire [15:0] sub_sel = first ? sub_wl[0] :
                          last  ? sub_wl[1] : 16'h0000;

    // Protection of the addressed regions by pins or lock bits.
    wire sect_prot = HW_PROTECT[sect] | sect_wl[sect];
    wire sub_lock  = |(sub_sel & sub_mask);
    wire page_ok   = ~sect_prot & ~sub_lock;
    wire sector_ok = ~sect_prot & ~(|sub_sel);
    wire sub_ok    = ~sect_prot & ~sub_lock;
    wire array_ok  = ~(|HW_PROTECT) & ~(|sect_wl) &
                     ~(|sub_wl[0]) & ~(|sub_wl[1]);

    // Commands recognised at their exact lengths.
    wire f_page  = len_addr & (cmd == CMD_PAGE_CLEAR);
    wire f_sect  = len_addr & (cmd == CMD_SECTOR_CLEAR);
    wire f_sub   = len_addr & (cmd == CMD_SUB_CLEAR);
    wire f_array = len_cmd & (cmd == CMD_ARRAY_CLEAR);
    wire f_pd    = len_cmd & (cmd == CMD_POWERDOWN);
    wire f_rel   = len_cmd & (cmd == CMD_RELEASE);
    wire f_wren  = len_cmd & (cmd == CMD_WRITE_ENABLE);
    wire f_wrdi  = len_cmd & (cmd == CMD_WRITE_DISABLE);
    wire f_lock  = len_lock & (cmd == CMD_LOCK_WRITE);

    // Only standby with no other cycle running accepts commands other than release;
    // deep power-down and the reset mode fall outside it.
    wire idle   = (state == sfe_pkg::ST_STANDBY) & ~EXT_BUSY;
    wire modify = frame_end & idle & WRITE_LATCH;

    wire go_page  = modify & f_page & page_ok;
    wire go_sect  = modify & f_sect & sector_ok;
    wire go_sub   = modify & f_sub & sub_ok;
    wire go_array = modify & f_array & array_ok;
    wire go_erase = go_page | go_sect | go_sub | go_array;
    wire go_pd    = frame_end & idle & f_pd;
    wire go_rel   = frame_end & (state == sfe_pkg::ST_DEEP) & f_rel;
    wire go_lock  = modify & f_lock;
    wire go_wren  = frame_end & idle & f_wren;
    wire go_wrdi  = frame_end & idle & f_wrdi;

    // A recognised erase, power-down or lock command that was refused gives a reject pulse.
    wire refused = frame_end &
                   (f_page | f_sect | f_sub | f_array | f_pd | f_lock) &
                   ~(go_erase | go_pd | go_lock);

    // Kind and length of the erase about to start.
    wire sfe_pkg::sfe_kind_type kind_sel =
        go_page ? sfe_pkg::KIND_PAGE :
        go_sect ? sfe_pkg::KIND_SECTOR :
        go_sub  ? sfe_pkg::KIND_SUB : sfe_pkg::KIND_ARRAY;
    wire [31:0] dur_sel =
        go_page ? PAGE_CLEAR_CYCLES :
        go_sect ? SECTOR_CLEAR_CYCLES :
        go_sub  ? SUB_CLEAR_CYCLES : ARRAY_CLEAR_CYCLES;

    // Region address as the engine sees it, cut to its own size.
    wire [20:0] addr_sel =
        go_page ? {addr[20:8], 8'h00} :
        go_sect ? {sect, 16'h0000} :
        go_sub  ? {sect, sub, 12'h000} : 21'h000000;

    // Mode sequencing; the reset pin overrides everything else.
    always_comb
    begin
        next_state = state;
        next_timer = (timer != 32'h0) ? 32'(timer - 32'h1) : timer;
        next_kind  = ERASE_KIND;
        next_addr  = ERASE_ADDR;
        case (state)
            sfe_pkg::ST_STANDBY:
            begin
                if (go_erase)
                begin
                    // Cycle length counts from the select rise.
                    next_state = sfe_pkg::ST_ERASE;
                    next_timer = 32'(dur_sel - 32'h1);
                    next_kind  = kind_sel;
                    next_addr  = addr_sel;
                end
                else if (go_pd)
                begin
                    next_state = sfe_pkg::ST_PD_WAIT;
                    next_timer = 32'(`SFE_PD_CYCLES - 1);
                end
            end
            sfe_pkg::ST_ERASE:
            begin
                // Any command here is refused without side effect.
                if (timer == 32'h0)
                    next_state = sfe_pkg::ST_STANDBY;
            end
            sfe_pkg::ST_PD_WAIT:
            begin
                if (timer == 32'h0)
                    next_state = sfe_pkg::ST_DEEP;
            end
            sfe_pkg::ST_DEEP:
            begin
                if (go_rel)
                    next_state = sfe_pkg::ST_STANDBY;
            end
            sfe_pkg::ST_RESET:
            begin
                // Select is ignored until the guard time runs out.
                if (timer == 32'h0)
                    next_state = sfe_pkg::ST_STANDBY;
            end
            default:
            begin
                next_state = sfe_pkg::ST_STANDBY;
            end
        endcase
        if (pin_reset)
        begin
            next_state = sfe_pkg::ST_RESET;
            next_timer = 32'(`SFE_RHSL_CYCLES - 1);
        end
    end

    // Write latch: set by enable, cleared by disable, by an accepted
    // lock write and as an erase starts; a set wins over a clear.
    assign next_latch = go_wren |
                        (WRITE_LATCH & ~go_wrdi & ~go_lock & ~go_erase);

    // Mode, timer and latch registers.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            state       <= sfe_pkg::ST_STANDBY;
            timer       <= 32'h0;
            sel_prev    <= 1'b1;
            WRITE_LATCH <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            timer       <= next_timer;
            sel_prev    <= pins_sync[1];
            WRITE_LATCH <= pin_reset ? 1'b0 : next_latch;
        end
    end

    // Registered outputs toward the erase engine and status logic.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            CYCLE_ACTIVE   <= 1'b0;
            DEEP_POWERDOWN <= 1'b0;
            ERASE_START    <= 1'b0;
            ERASE_ABORT    <= 1'b0;
            ERASE_KIND     <= sfe_pkg::KIND_PAGE;
            ERASE_ADDR     <= 21'h000000;
            CMD_REJECT     <= 1'b0;
        end
        else
        begin
            CYCLE_ACTIVE   <= (next_state == sfe_pkg::ST_ERASE);
            DEEP_POWERDOWN <= (next_state == sfe_pkg::ST_DEEP);
            ERASE_START    <= go_erase & ~pin_reset;
            ERASE_ABORT    <= pin_reset & (state == sfe_pkg::ST_ERASE);
            ERASE_KIND     <= next_kind;
            ERASE_ADDR     <= next_addr;
            CMD_REJECT     <= refused & ~pin_reset;
        end
    end

    // Sector lock bits, one slice per sector. Once the freeze bit is
    // set only a reset can unlock the sector again.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_sect
            wire special = (gi == 0) || (gi == 31);
            wire hit = go_lock & (sect == 5'(gi)) & ~sect_ld[gi] &
                       ~(special & lk[`SFE_LK_SUB]);

            // Write-lock first, then the freeze bit.
            always_ff @(posedge MCLK)
            begin
                if (SRST || pin_reset)
                begin
                    sect_wl[gi] <= 1'b0;
                    sect_ld[gi] <= 1'b0;
                end
                else if (hit)
                begin
                    sect_wl[gi] <= lk[`SFE_LK_WL];
                    sect_ld[gi] <= sect_ld[gi] | lk[`SFE_LK_LD];
                end
            end
        end
    endgenerate

    // Subsector lock bits of the first and the last sector.
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_end
            wire [4:0] own = (gi == 0) ? 5'h00 : `SFE_SECT_LAST;
            wire on_me = go_lock & (sect == own);
            wire sec_hit = on_me & ~lk[`SFE_LK_SUB] & ~sect_ld[own];
            wire sub_hit = on_me & lk[`SFE_LK_SUB] &
                           ~(|(sub_ld[gi] & sub_mask));

            // Locking the sector forces every subsector locked, even
            // frozen ones; unlocking frees only unfrozen subsectors.
            wire [15:0] wl_sec = lk[`SFE_LK_WL] ? 16'hffff :
                                 (sub_wl[gi] & sub_ld[gi]);
            wire [15:0] wl_sub = (sub_wl[gi] & ~sub_mask) |
                                 (lk[`SFE_LK_SUB_WL] ? sub_mask : 16'h0000);
            wire [15:0] ld_set = sec_hit ?
                                 {16{lk[`SFE_LK_LD]}} :
                                 (lk[`SFE_LK_SUB_LD] ? sub_mask : 16'h0000);

            // Freeze bits follow the write-lock update of the same word.
            always_ff @(posedge MCLK)
            begin
                if (SRST || pin_reset)
                begin
                    sub_wl[gi] <= 16'h0000;
                    sub_ld[gi] <= 16'h0000;
                end
                else if (sec_hit || sub_hit)
                begin
                    sub_wl[gi] <= sec_hit ? wl_sec : wl_sub;
                    sub_ld[gi] <= sub_ld[gi] | ld_set;
                end
            end
        end
    endgenerate

endmodule

// ---- test/sfe_erase_ctl_monitor.sv ----
// Port checker for the erase and power-down sequencer.
module sfe_erase_ctl_monitor (
    input wire logic            MCLK,
    input wire logic            SRST,
    input wire logic            RESET_N,
    input wire logic [31:0]     HW_PROTECT,
    input wire logic            CYCLE_ACTIVE,
    input wire logic            WRITE_LATCH,
    input wire logic            DEEP_POWERDOWN,
    input wire logic            ERASE_START,
    input wire logic            ERASE_ABORT,
    input sfe_pkg::sfe_kind_type ERASE_KIND,
    input wire logic [20:0]     ERASE_ADDR,
    input wire logic            CMD_REJECT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    // The pin passes two sync flops, so five low samples are enough.
    sequence s_pin_low;
        !RESET_N [*5];
    endsequence
    sequence s_kind_start(sfe_pkg::sfe_kind_type k);
        ERASE_START && ERASE_KIND == k;
    endsequence
    property p_pin_clears;
        s_pin_low |-> !CYCLE_ACTIVE && !WRITE_LATCH && !DEEP_POWERDOWN;
    endproperty
    a_pin_clears: assert property (p_pin_clears)
        else $error("reset pin left a cycle or the latch set");
    property p_start_act;
        ERASE_START |-> CYCLE_ACTIVE && !WRITE_LATCH;
    endproperty
    a_start_act: assert property (p_start_act)
        else $error("erase start without active flag or with latch");
    property p_start_once;
        ERASE_START |=> !ERASE_START;
    endproperty
    a_start_once: assert property (p_start_once)
        else $error("erase start pulse longer than one cycle");
    property p_rej_once;
        CMD_REJECT |=> !CMD_REJECT;
    endproperty
    a_rej_once: assert property (p_rej_once)
        else $error("refusal pulse longer than one cycle");
    property p_need_latch;
        $rose(CYCLE_ACTIVE) |-> $past(WRITE_LATCH);
    endproperty
    a_need_latch: assert property (p_need_latch)
        else $error("erase began with the latch clear");
    property p_no_restart;
        ERASE_START |-> !$past(CYCLE_ACTIVE) && !$past(DEEP_POWERDOWN);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("erase started while busy or powered down");
    property p_abort;
        ERASE_ABORT |-> $past(CYCLE_ACTIVE);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort pulse with no erase running");
    property p_array;
        s_kind_start(sfe_pkg::KIND_ARRAY) |-> HW_PROTECT == 32'h0;
    endproperty
    a_array: assert property (p_array)
        else $error("array erase ran with a protected sector");
    property p_sector;
        s_kind_start(sfe_pkg::KIND_SECTOR) |-> !HW_PROTECT[ERASE_ADDR[20:16]];
    endproperty
    a_sector: assert property (p_sector)
        else $error("sector erase ran on a protected sector");
    property p_page_base;
        s_kind_start(sfe_pkg::KIND_PAGE) |-> ERASE_ADDR[7:0] == 8'h00;
    endproperty
    a_page_base: assert property (p_page_base)
        else $error("page erase base not page aligned");
    property p_pd_entry;
        $rose(DEEP_POWERDOWN) |-> !CYCLE_ACTIVE && !ERASE_START;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down entered while an erase ran");
endmodule

bind sfe_erase_ctl sfe_erase_ctl_monitor i_sfe_erase_ctl_monitor (
    .MCLK, .SRST, .RESET_N, .HW_PROTECT, .CYCLE_ACTIVE, .WRITE_LATCH,
    .DEEP_POWERDOWN, .ERASE_START, .ERASE_ABORT, .ERASE_KIND,
    .ERASE_ADDR, .CMD_REJECT
);

// ---- test/sfe_host.sv ----
// Serial host model that frames commands on select, clock and data.
module sfe_host (
    output logic sclk,
    output logic sel_n,
    output logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b0;
        sdo = 1'b0;
        #1 sel_n = 1'b1; // Rise clears the link.
    end
    // Shift len bits of v, MSB first; the clock stands still between frames.
    task automatic send(input int len, input logic [39:0] v);
        #7 sel_n = 1'b0;
        for (int i = len - 1; i >= 0; i--)
        begin
            sdo = v[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #12 sel_n = 1'b1;
        // A released line must not keep its last bit.
        sdo = ~sdo;
        #200;
    endtask
endmodule

// ---- test/sfe_erase_ctl_tb.sv ----
// Self-checking bench for the erase and power-down sequencer.
`include "sfe_regs.svh"
module sfe_erase_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] C_WE = `SFE_CMD_WRITE_ENABLE;
    localparam logic [7:0] C_LK = `SFE_CMD_LOCK_WRITE;
    localparam logic [7:0] C_PG = `SFE_CMD_PAGE_CLEAR;
    localparam logic [7:0] C_SE = `SFE_CMD_SECTOR_CLEAR;
    localparam logic [7:0] C_SU = `SFE_CMD_SUB_CLEAR;
    localparam logic [7:0] C_AR = `SFE_CMD_ARRAY_CLEAR;
    logic        mclk, srst, reset_n, ext_busy, sclk, sel_n, sdo;
    logic [31:0] hw_prot;
    logic        cyc, write_latch_flag, deep, start, abrt, rej;
    logic [20:0] eaddr;
    sfe_pkg::sfe_kind_type kind;
    int          bad_count, compares, starts, rejects, aborts, act;
    always #20 mclk = ~mclk;
    sfe_erase_ctl #(.PAGE_CLEAR_CYCLES(32'd200), .SECTOR_CLEAR_CYCLES(32'd60),
        .SUB_CLEAR_CYCLES(32'd50), .ARRAY_CLEAR_CYCLES(32'd80))
    i_sfe_erase_ctl (.MCLK(mclk), .SRST(srst), .SCLK(sclk), .SEL_N(sel_n),
        .SERIAL_IN(sdo), .RESET_N(reset_n), .HW_PROTECT(hw_prot),
        .EXT_BUSY(ext_busy), .CYCLE_ACTIVE(cyc), .WRITE_LATCH(write_latch_flag),
        .DEEP_POWERDOWN(deep), .ERASE_START(start), .ERASE_ABORT(abrt),
        .ERASE_KIND(kind), .ERASE_ADDR(eaddr), .CMD_REJECT(rej));
    sfe_host i_sfe_host (.sclk(sclk), .sel_n(sel_n), .sdo(sdo));
    // Event counters, so that one-cycle pulses are never missed.
    always @(posedge mclk)
    begin
        starts <= starts + (start === 1'b1);
        rejects <= rejects + (rej === 1'b1);
        aborts <= aborts + (abrt === 1'b1);
        act <= act + (cyc === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cw(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr_en;
        i_sfe_host.send(8, {32'h0, C_WE});
    endtask
    task automatic lk(input logic [23:0] a, input logic [7:0] d);
        wr_en();
        i_sfe_host.send(40, {C_LK, a, d});
        cw(4);
    endtask
    // One erase frame; judges start, refusal and the active span.
    task automatic erase(input logic [7:0] c, input logic [23:0] a,
                         input logic we, input logic ok, input int n);
        int s, r, t;
        if (we)
            wr_en();
        s = starts;
        r = rejects;
        t = act;
        if (c == C_AR)
            i_sfe_host.send(8, {32'h0, c});
        else
            i_sfe_host.send(32, {8'h0, c, a});
        cw(n + 8);
        check(starts - s, ok);
        check(rejects - r, !ok);
        check(act - t, ok ? n : 0);
        if (ok)
            check(write_latch_flag, 1'b0);
    endtask
    task automatic t_kinds;
        check({cyc, write_latch_flag, deep, start, abrt, rej}, 6'h00);
        erase(C_PG, 24'he12345, 0, 0, 200);
        erase(C_PG, 24'he12345, 1, 1, 200);
        check({kind, eaddr}, {sfe_pkg::KIND_PAGE, 21'h012300});
        @(negedge mclk) hw_prot = 32'h8;
        erase(C_SE, 24'h038000, 1, 0, 60);
        erase(C_PG, 24'h030100, 1, 0, 0);
        erase(C_SU, 24'h038000, 1, 0, 0);
        @(negedge mclk) hw_prot = 32'h0;
        erase(C_SE, 24'h038000, 1, 1, 60);
        check({kind, eaddr}, {sfe_pkg::KIND_SECTOR, 21'h030000});
        erase(C_SU, 24'h057abc, 1, 1, 50);
        check({kind, eaddr}, {sfe_pkg::KIND_SUB, 21'h057000});
        @(negedge mclk) hw_prot = 32'h80000000;
        erase(C_AR, 24'h0, 1, 0, 80);
        @(negedge mclk) hw_prot = 32'h0;
        erase(C_AR, 24'h0, 1, 1, 80);
        check({kind, eaddr}, {sfe_pkg::KIND_ARRAY, 21'h0});
    endtask
    // Short frames and frames during a running cycle must not start work.
    task automatic t_busy;
        int s, t;
        wr_en();
        s = starts;
        t = act;
        i_sfe_host.send(31, {9'h0, C_PG, 23'h0});
        cw(10);
        check(starts - s, 0);
        i_sfe_host.send(32, {8'h0, C_PG, 24'h001000});
        cw(20);
        wr_en();
        i_sfe_host.send(32, {8'h0, C_SE, 24'h020000});
        cw(200);
        check(starts - s, 1);
        check(act - t, 200);
        @(negedge mclk) ext_busy = 1'b1;
        wr_en();
        i_sfe_host.send(32, {8'h0, C_PG, 24'h0});
        cw(10);
        check(starts - s, 1);
        @(negedge mclk) ext_busy = 1'b0;
    endtask
    task automatic t_locks;
        lk(24'h050000, 8'h01);
        erase(C_SE, 24'h050000, 1, 0, 60);
        erase(C_AR, 24'h0, 1, 0, 80);
        lk(24'h050000, 8'h00);
        erase(C_SE, 24'h050000, 1, 1, 60);
        lk(24'h1f2000, 8'h84);
        erase(C_SU, 24'h1f2000, 1, 0, 50);
        lk(24'h1f0000, 8'h00);
        erase(C_SU, 24'h1f2000, 1, 1, 50);
        lk(24'h1f2000, 8'h84);
        lk(24'h1f0000, 8'h02);
        erase(C_SU, 24'h1f2000, 1, 1, 50);
    endtask
    task automatic t_power;
        int s;
        s = starts;
        i_sfe_host.send(8, {32'h0, `SFE_CMD_POWERDOWN});
        cw(65);
        check(deep, 1'b0);
        cw(20);
        check(deep, 1'b1);
        wr_en();
        i_sfe_host.send(32, {8'h0, C_PG, 24'h0});
        cw(10);
        check({write_latch_flag, 31'(starts - s)}, 32'h0);
        i_sfe_host.send(8, {32'h0, `SFE_CMD_RELEASE});
        cw(2);
        check(deep, 1'b0);
        i_sfe_host.send(8, {32'h0, `SFE_CMD_POWERDOWN});
        cw(90);
        srst = 1'b1;
        cw(2);
        srst = 1'b0;
        cw(4);
        check(deep, 1'b0);
    endtask
    task automatic t_pin;
        int a;
        wr_en();
        i_sfe_host.send(32, {8'h0, C_SE, 24'h010000});
        cw(10);
        a = aborts;
        reset_n = 1'b0;
        cw(8);
        check({30'(aborts - a), cyc, write_latch_flag}, 32'h4);
        reset_n = 1'b1;
        cw(800);
        erase(C_PG, 24'h000100, 1, 1, 200);
    endtask
    initial
    begin
        mclk = 1'b0;
        srst = 1'b1;
        reset_n = 1'b1;
        ext_busy = 1'b0;
        hw_prot = 32'h0;
        cw(6);
        srst = 1'b0;
        cw(4);
        t_kinds();
        t_busy();
        t_locks();
        t_power();
        t_pin();
        give_verdict();
    end
    initial
    begin
        #2000000;
        bad_count++;
        give_verdict();
    end
endmodule
